// >>> verilog/sfh_ctrl.v
// Serial flash host controller: APB registers in, flash frames out.
// Behaviour
// - Single reads: 24-bit address, fast read dummy byte
// - Dual output read: address, dummy, two-lane data
// - Dual address: address and mode two per clock
// - Quad address: address and mode four per clock
// - Quad address read: four dummy clocks, quad data
// - Quad word read: two dummy clocks only
// - Wrap setup: wrap bits on lanes of clock seven
// - Power-down release: three dummies, repeating part code
// - Maker/part code reads in single, dual, quad
// - Security registers: middle byte picks the register
// - Prefer security registers one to three first
// - Write enable precedes every program or erase
// - Volatile enable directly before status write
// - Opcode first byte, MSB first, rising edge
`include "sfh_defs.vh"

module sfh_ctrl (
  input  wire        pclk,           // System clock, 20 MHz.
  input  wire        presetn,        // Asynchronous reset, active low.
  input  wire        psel,           // APB select.
  input  wire        penable,        // APB enable.
  input  wire        pwrite,         // APB direction, high for write.
  input  wire [11:0] paddr,          // APB byte address.
  input  wire [31:0] pwdata,         // APB write data.
  output reg  [31:0] prdata,         // APB read data.
  output wire        pready,         // APB ready, always high.
  output wire        pslverr,        // APB error on unmapped offsets.
  output reg         flash_sclk,     // Serial clock to the flash.
  output reg         flash_cs_n,     // Chip select, active low.
  output reg  [3:0]  flash_lane_out, // Lane drive, bit 0 is lane_zero.
  output reg  [3:0]  flash_lane_oe,  // Lane output enables, high drives.
  input  wire [3:0]  flash_lane_in   // Lane levels, bit 1 is lane_one.
);

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam integer HALF_LAST = `SFH_HALF_CYC - 1;
  localparam [2:0] ST_IDLE  = 3'h0;  // Select high, waiting for go.
  localparam [2:0] ST_SHIFT = 3'h1;  // Clocking a frame.
  localparam [2:0] ST_HOLD  = 3'h2;  // Last clock done, select still low.
  localparam [2:0] ST_GAP   = 3'h3;  // Select high between frames.
  localparam [1:0] PH_OPC   = 2'h0;  // Opcode byte.
  localparam [1:0] PH_ADR   = 2'h1;  // Address and mode bits.
  localparam [1:0] PH_DUM   = 2'h2;  // Don't-care clocks.
  localparam [1:0] PH_DAT   = 2'h3;  // Data bytes.

  // ==========================================================================
  // Declarations
  // ==========================================================================
  reg  [7:0]  opcode_reg;      // Opcode of the main frame.
  reg  [31:0] addr_reg;        // Address in 23:0, mode bits in 31:24.
  reg  [14:0] fmt_reg;         // Frame format fields.
  reg  [31:0] wdata_reg;       // Bytes to send in a write data phase.
  reg  [31:0] rdata_reg;       // Bytes taken in the last read data phase.
  reg         done_reg;        // Sticky: a command finished.
  reg         sr0_reg;         // Sticky: security register 0 was addressed.
  reg  [2:0]  st_reg;          // Engine state.
  reg  [1:0]  ph_reg;          // Frame phase.
  reg  [5:0]  clk_left_reg;    // Serial clocks left in this phase.
  reg  [1:0]  w_reg;           // Lane width code of this phase.
  reg  [31:0] tx_sh_reg;       // Outgoing bits, next bits at the top.
  reg  [31:0] rx_sh_reg;       // Incoming bits, last bits at the bottom.
  reg         pre_pend_reg;    // The current frame is the enable preamble.
  reg  [2:0]  div_reg;         // Half-period divider.
  wire [3:0]  lane_s;          // Synchronised lane inputs.
  wire        busy;            // A command is in progress.
  wire        wr_acc;          // APB write access phase.
  wire        go;              // Start request accepted.
  wire        tick;            // One-cycle enable, once per half period.
  wire        rd_dat;          // In a read data phase.
  wire        done_set;        // Last frame ended.
  wire        sr0_set;         // Start of a security command to register 0.
  wire [7:0]  pre_op;          // Preamble opcode.
  wire [7:0]  first_op;        // First opcode sent after go.
  wire [5:0]  dat_bits;        // Data phase length in bits.
  reg  [1:0]  nx_ph;           // Next phase after the current one.
  reg         nx_end;          // The frame ends after the current phase.
  reg  [5:0]  ld_clk;          // Clock count to load for nx_ph.
  reg  [1:0]  ld_w;            // Lane width to load for nx_ph.
  reg  [31:0] ld_tx;           // Shift value to load for nx_ph.
  reg  [3:0]  ld_oe;           // Output enables to load for nx_ph.
  reg  [31:0] tx_nx;           // Shift register after one clock.
  reg  [31:0] rx_nx;           // Receive register after one clock.

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Top bits of the shift register onto the lanes; highest pair or nibble
  // goes first, so odd positions land on lane one and bit n on lane n.
  function [3:0] out_bits;
    input [31:0] sh;
    input [1:0]  w;
    begin
      if (w == `SFH_LANES_1)
        out_bits = {3'h0, sh[31]};
      else if (w == `SFH_LANES_2)
        out_bits = {2'h0, sh[31:30]};
      else
        out_bits = sh[31:28];
    end
  endfunction

  // Lanes the host drives for a given width.
  function [3:0] lane_mask;
    input [1:0] w;
    begin
      if (w == `SFH_LANES_1)
        lane_mask = 4'h1;
      else if (w == `SFH_LANES_2)
        lane_mask = 4'h3;
      else
        lane_mask = 4'hf;
    end
  endfunction

  // ==========================================================================
  // Input synchroniser
  // ==========================================================================
  sfh_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (flash_lane_in),
    .q_out   (lane_s)
  );

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign pready   = 1'b1;
  assign busy     = (st_reg != ST_IDLE);
  assign wr_acc   = psel & penable & pwrite;
  assign go       = wr_acc & (paddr == `SFH_OFF_CTRL) & pwdata[`SFH_CTRL_GO] & ~busy;
  assign pslverr  = psel & penable & (paddr != `SFH_OFF_CTRL) & (paddr != `SFH_OFF_ADDR) &
                    (paddr != `SFH_OFF_FMT) & (paddr != `SFH_OFF_DATA) &
                    (paddr != `SFH_OFF_STAT);
  // Register 0 is held back by the maker; software is warned when it is hit.
  assign sr0_set  = go & (addr_reg[15:8] == `SFH_SEC_REG0) &
                    ((pwdata[7:0] == `SFH_OP_SEC_ERASE) | (pwdata[7:0] == `SFH_OP_SEC_PROG) |
                     (pwdata[7:0] == `SFH_OP_SEC_READ));

  // Register writes; setup registers are frozen while busy so the frame
  // being clocked cannot change under the engine. Sticky flags clear by
  // writing one, and a set in the same cycle wins.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opcode_reg <= `SFH_RST_OPCODE;
      addr_reg   <= `SFH_RST_WORD;
      fmt_reg    <= `SFH_RST_FMT;
      wdata_reg  <= `SFH_RST_WORD;
      done_reg   <= 1'b0;
      sr0_reg    <= 1'b0;
    end
    else
    begin
      if (wr_acc && !busy)
      begin
        if (paddr == `SFH_OFF_CTRL)
          opcode_reg <= pwdata[7:0];
        else if (paddr == `SFH_OFF_ADDR)
          addr_reg <= pwdata;
        else if (paddr == `SFH_OFF_FMT)
        begin
          fmt_reg <= pwdata[14:0];
          // Counts above four bytes are clipped to the data register size.
          if (pwdata[`SFH_FMT_COUNT] > `SFH_MAX_COUNT)
            fmt_reg[`SFH_FMT_COUNT] <= `SFH_MAX_COUNT;
        end
        else if (paddr == `SFH_OFF_DATA)
          wdata_reg <= pwdata;
      end
      done_reg <= done_set | (done_reg & ~(wr_acc && paddr == `SFH_OFF_STAT &&
                                           pwdata[`SFH_STAT_DONE]));
      sr0_reg  <= sr0_set | (sr0_reg & ~(wr_acc && paddr == `SFH_OFF_STAT &&
                                         pwdata[`SFH_STAT_SR0]));
    end
  end

  // Read data is captured in the setup cycle so it comes from a flip-flop
  // by the access cycle, keeping the slave at zero wait states.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `SFH_RST_WORD;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == `SFH_OFF_CTRL)
        prdata <= {24'h0, opcode_reg};
      else if (paddr == `SFH_OFF_ADDR)
        prdata <= addr_reg;
      else if (paddr == `SFH_OFF_FMT)
        prdata <= {17'h0, fmt_reg};
      else if (paddr == `SFH_OFF_DATA)
        prdata <= rdata_reg;
      else if (paddr == `SFH_OFF_STAT)
        prdata <= {29'h0, sr0_reg, done_reg, busy};
      else
        prdata <= `SFH_RST_WORD;
    end
  end

  // ==========================================================================
  // Phase planning
  // ==========================================================================
  // Either write enable precedes the main frame in a frame of its own;
  // select rises between them so the device sees two complete instructions.
  assign pre_op   = fmt_reg[`SFH_FMT_PRE_VOL] ? `SFH_OP_VWREN : `SFH_OP_WREN;
  // The start write carries the opcode; opcode_reg only catches it at that edge.
  assign first_op = fmt_reg[`SFH_FMT_PRE_EN] ? pre_op : pwdata[7:0];
  assign dat_bits = {fmt_reg[`SFH_FMT_COUNT], 3'h0};
  assign rd_dat   = (ph_reg == PH_DAT) & ~fmt_reg[`SFH_FMT_WRITE];
  assign tick     = (div_reg == HALF_LAST[2:0]);
  assign done_set = (st_reg == ST_GAP) & tick & ~pre_pend_reg;

  // Chooses the next non-empty phase and what to load for it. Dummy and
  // read data phases leave every lane released for the device.
  always @*
  begin
    nx_ph  = PH_DAT;
    nx_end = 1'b0;
    if (ph_reg == PH_OPC && pre_pend_reg)
      nx_end = 1'b1;
    else if (ph_reg == PH_OPC && fmt_reg[`SFH_FMT_AMODE] != 2'h0)
      nx_ph = PH_ADR;
    else if (ph_reg != PH_DUM && ph_reg != PH_DAT && fmt_reg[`SFH_FMT_DUMMY] != 4'h0)
      nx_ph = PH_DUM;
    else if (ph_reg != PH_DAT && fmt_reg[`SFH_FMT_COUNT] != 3'h0)
      nx_ph = PH_DAT;
    else
      nx_end = 1'b1;
    ld_w   = `SFH_LANES_1;
    ld_clk = {2'h0, fmt_reg[`SFH_FMT_DUMMY]};
    ld_tx  = `SFH_RST_WORD;
    ld_oe  = 4'h0;
    if (nx_ph == PH_ADR)
    begin
      ld_w   = fmt_reg[`SFH_FMT_AMODE] - 2'h1;
      ld_clk = (fmt_reg[`SFH_FMT_MODE_EN] ? `SFH_ADRM_BITS : `SFH_ADR_BITS) >> ld_w;
      ld_tx  = {addr_reg[23:0], fmt_reg[`SFH_FMT_MODE_EN] ? addr_reg[31:24] : 8'h00};
      ld_oe  = lane_mask(ld_w);
    end
    else if (nx_ph == PH_DAT)
    begin
      ld_w   = (fmt_reg[`SFH_FMT_DLANES] > `SFH_LANES_4) ? `SFH_LANES_4 :
               fmt_reg[`SFH_FMT_DLANES];
      ld_clk = dat_bits >> ld_w;
      ld_tx  = wdata_reg << (6'h20 - dat_bits);
      ld_oe  = fmt_reg[`SFH_FMT_WRITE] ? lane_mask(ld_w) : 4'h0;
    end
  end

  // Shift both registers by one clock's worth of lanes. Single-lane reads
  // take lane one; dual reads pair lane one above lane zero.
  always @*
  begin
    if (w_reg == `SFH_LANES_1)
    begin
      tx_nx = {tx_sh_reg[30:0], 1'b0};
      rx_nx = {rx_sh_reg[30:0], lane_s[1]};
    end
    else if (w_reg == `SFH_LANES_2)
    begin
      tx_nx = {tx_sh_reg[29:0], 2'h0};
      rx_nx = {rx_sh_reg[29:0], lane_s[1:0]};
    end
    else
    begin
      tx_nx = {tx_sh_reg[27:0], 4'h0};
      rx_nx = {rx_sh_reg[27:0], lane_s};
    end
  end

  // ==========================================================================
  // Frame engine
  // ==========================================================================
  // Mode 0 framing: the host changes lanes while the clock is low and the
  // device samples on the rise; read data is taken at the host's rise,
  // two full system cycles after the synchroniser has settled.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg         <= ST_IDLE;
      ph_reg         <= PH_OPC;
      clk_left_reg   <= 6'h00;
      w_reg          <= `SFH_LANES_1;
      tx_sh_reg      <= `SFH_RST_WORD;
      rx_sh_reg      <= `SFH_RST_WORD;
      rdata_reg      <= `SFH_RST_WORD;
      pre_pend_reg   <= 1'b0;
      div_reg        <= 3'h0;
      flash_sclk     <= 1'b0;
      flash_cs_n     <= 1'b1;
      flash_lane_out <= 4'h0;
      flash_lane_oe  <= 4'h0;
    end
    else
    begin
      div_reg <= (tick || st_reg == ST_IDLE) ? 3'h0 : div_reg + 3'h1;
      case (st_reg)
        ST_IDLE:
        begin
          if (go)
          begin
            pre_pend_reg   <= fmt_reg[`SFH_FMT_PRE_EN];
            flash_cs_n     <= 1'b0;
            ph_reg         <= PH_OPC;
            w_reg          <= `SFH_LANES_1;
            clk_left_reg   <= `SFH_OPC_CLKS;
            tx_sh_reg      <= {first_op, 24'h0};
            rx_sh_reg      <= `SFH_RST_WORD;
            flash_lane_out <= {3'h0, first_op[7]};
            flash_lane_oe  <= lane_mask(`SFH_LANES_1);
            st_reg         <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (tick && !flash_sclk)
          begin
            flash_sclk   <= 1'b1;
            clk_left_reg <= clk_left_reg - 6'h01;
            if (rd_dat)
              rx_sh_reg <= rx_nx;
          end
          else if (tick)
          begin
            flash_sclk <= 1'b0;
            if (clk_left_reg != 6'h00)
            begin
              tx_sh_reg      <= tx_nx;
              flash_lane_out <= out_bits(tx_nx, w_reg);
            end
            else if (nx_end)
            begin
              flash_lane_oe <= 4'h0;
              st_reg        <= ST_HOLD;
            end
            else
            begin
              ph_reg         <= nx_ph;
              w_reg          <= ld_w;
              clk_left_reg   <= ld_clk;
              tx_sh_reg      <= ld_tx;
              flash_lane_out <= out_bits(ld_tx, ld_w);
              flash_lane_oe  <= ld_oe;
            end
          end
        end
        ST_HOLD:
        begin
          // Every phase but the dummy one is a whole number of bytes, so select rises
          // on a byte boundary unless the frame ends in dummy clocks, and a write is never dropped for that.
          if (tick)
          begin
            flash_cs_n <= 1'b1;
            if (rd_dat)
              rdata_reg <= rx_sh_reg;
            st_reg <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (tick && pre_pend_reg)
          begin
            pre_pend_reg   <= 1'b0;
            flash_cs_n     <= 1'b0;
            ph_reg         <= PH_OPC;
            w_reg          <= `SFH_LANES_1;
            clk_left_reg   <= `SFH_OPC_CLKS;
            tx_sh_reg      <= {opcode_reg, 24'h0};
            flash_lane_out <= {3'h0, opcode_reg[7]};
            flash_lane_oe  <= lane_mask(`SFH_LANES_1);
            st_reg         <= ST_SHIFT;
          end
          else if (tick)
            st_reg <= ST_IDLE;
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// >>> verilog/sfh_defs.vh
// Shared constants for the serial flash host controller.
`ifndef SFH_DEFS_VH
`define SFH_DEFS_VH

// ==========================================================================
// Timing
// ==========================================================================
`define SFH_CLK_NS        50
`define SFH_SCLK_HALF_NS  200
`define SFH_HALF_CYC      (`SFH_SCLK_HALF_NS / `SFH_CLK_NS)

// ==========================================================================
// APB register offsets (byte addresses)
// ==========================================================================
`define SFH_OFF_CTRL      12'h000
`define SFH_OFF_ADDR      12'h004
`define SFH_OFF_FMT       12'h008
`define SFH_OFF_DATA      12'h00c
`define SFH_OFF_STAT      12'h010

// ==========================================================================
// Field positions
// ==========================================================================
`define SFH_CTRL_GO       8
`define SFH_FMT_AMODE     1:0
`define SFH_FMT_MODE_EN   2
`define SFH_FMT_DUMMY     6:3
`define SFH_FMT_DLANES    8:7
`define SFH_FMT_WRITE     9
`define SFH_FMT_COUNT     12:10
`define SFH_FMT_PRE_EN    13
`define SFH_FMT_PRE_VOL   14
`define SFH_FMT_BITS      15
`define SFH_STAT_BUSY     0
`define SFH_STAT_DONE     1
`define SFH_STAT_SR0      2

// ==========================================================================
// Reset values and opcodes
// ==========================================================================
`define SFH_RST_OPCODE    8'h05
`define SFH_RST_WORD      32'h0000_0000
`define SFH_RST_FMT       15'h0000
`define SFH_MAX_COUNT     3'h4
`define SFH_OP_WREN       8'h06
`define SFH_OP_VWREN      8'h50
`define SFH_OP_SEC_ERASE  8'h44
`define SFH_OP_SEC_PROG   8'h42
`define SFH_OP_SEC_READ   8'h48
`define SFH_SEC_REG0      8'h00

// ==========================================================================
// Frame geometry
// ==========================================================================
`define SFH_OPC_CLKS      6'h08
`define SFH_ADR_BITS      6'h18
`define SFH_ADRM_BITS     6'h20
`define SFH_LANES_1       2'h0
`define SFH_LANES_2       2'h1
`define SFH_LANES_4       2'h2

`endif

// >>> verilog/sfh_sync.v
// Two flip-flop synchroniser for a group of pin inputs.
module sfh_sync #(
  parameter W = 4
) (
  input  wire         pclk,     // System clock.
  input  wire         presetn,  // Asynchronous reset, active low.
  input  wire [W-1:0] d_in,     // Asynchronous inputs.
  output wire [W-1:0] q_out     // Synchronised outputs.
);

  reg [W-1:0] meta_reg;  // First stage, read only by the second stage.
  reg [W-1:0] sync_reg;  // Second stage, safe for logic.

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  // Both stages clear to zero so the outputs are defined from reset onward.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;

endmodule

// >>> dv/sfh_ctrl_sva.sv
// Assertion checker for the host controller's bus and flash pins.
module sfh_ctrl_sva (
  input wire logic        pclk,           // Bus clock.
  input wire logic        presetn,        // Reset, active low.
  input wire logic        psel,           // Bus select.
  input wire logic        penable,        // Access phase.
  input wire logic [11:0] paddr,          // Byte address.
  input wire logic        pready,         // Ready.
  input wire logic        pslverr,        // Error response.
  input wire logic        flash_sclk,     // Serial clock.
  input wire logic        flash_cs_n,     // Select, active low.
  input wire logic [3:0]  flash_lane_out, // Lane drive.
  input wire logic [3:0]  flash_lane_oe   // Lane enables.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Helper: serial clock rises seen in the current frame.
  // ==========================================================
  logic [5:0] rises; // Saturates so long frames cannot wrap.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rises <= 6'h00;
    else if (flash_cs_n)
      rises <= 6'h00;
    else if ($rose(flash_sclk) && rises != 6'h3f)
      rises <= rises + 6'h01;
  // ==========================================================
  // Properties.
  // ==========================================================
  a_ready_const: assert property (pready) else $error("pready low");
  a_err_map: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > 12'h010)) else $error("pslverr wrong");
  a_idle_pins: assert property (flash_cs_n |-> !flash_sclk && flash_lane_oe == 4'h0)
    else $error("pins busy while deselected");
  a_first_rise: assert property ($fell(flash_cs_n) |-> !flash_sclk [*4] ##1 flash_sclk)
    else $error("first rise misplaced");
  a_half_high: assert property ($rose(flash_sclk) |-> flash_sclk [*4] ##1 !flash_sclk)
    else $error("high half wrong");
  a_half_low: assert property ($fell(flash_sclk) |-> !flash_sclk [*4] ##[1:2]
    (flash_sclk || flash_cs_n)) else $error("low half wrong");
  a_lane_hold: assert property ($rose(flash_sclk) |-> $stable(flash_lane_out)
    && $stable(flash_lane_oe)) else $error("lanes moved at rise");
  a_opc_lane: assert property (!flash_cs_n && rises < 6'h08 |-> flash_lane_oe == 4'h1)
    else $error("opcode not on single lane");
  a_cs_gap: assert property ($rose(flash_cs_n) |-> flash_cs_n [*4])
    else $error("deselect too short");
endmodule

bind sfh_ctrl sfh_ctrl_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n), .flash_lane_out(flash_lane_out),
  .flash_lane_oe(flash_lane_oe));

// >>> dv/sfh_flash_dev.sv
// Behavioural flash device answering the host controller's frames.
module sfh_flash_dev #(
  parameter logic [7:0] SR2   = 8'h62, // Status two; bit 1 is the quad_lane_enable_bit.
  parameter logic [7:0] DBYTE = 8'h96  // Byte returned by every array read.
) (
  input  wire logic       sclk,  // Serial clock.
  input  wire logic       cs_n,  // Select, active low.
  input  wire logic [3:0] lanes, // Resolved lane levels.
  output logic      [3:0] d_out, // Device lane drive.
  output logic      [3:0] d_oe   // Device lane enables.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] opc;         // Opcode shifted in.
  int         rises = 0;   // Rises in this frame.
  logic       write_enable_latch = 1'b0;  // write_enable_latch, clear at power-up.
  logic       vol = 1'b0;  // Volatile status write armed.
  logic [8:0] sn;          // Data start clock and lane count.
  logic [7:0] db;          // Byte shifted out.
  int         p;           // Bit position within the byte.
  initial d_oe = 4'h0;
  initial d_out = 4'h0;
  // ==========================================================
  // Framing: a new select restarts decoding.
  // ==========================================================
  always @(negedge cs_n)
    rises = 0;
  always @(posedge sclk)
  begin
    if (rises < 8)
      opc = {opc[6:0], lanes[0]};
    rises = rises + 1;
  end
  // Latch updates only on whole single-byte frames.
  always @(posedge cs_n)
  begin
    d_oe = 4'h0;
    if (rises == 8 && opc == 8'h06)
      write_enable_latch = 1'b1;
    if (rises == 8 && opc == 8'h50)
      vol = 1'b1;
    if (rises == 8 && opc == 8'h04)
      {write_enable_latch, vol} = 2'b00;
  end
  // ==========================================================
  // Read geometry: first data clock and lanes per opcode.
  // ==========================================================
  always_comb
    case (opc)
      8'h03:        sn = {6'd32, 3'd1};
      8'h0b, 8'h48: sn = {6'd40, 3'd1};
      8'h3b:        sn = {6'd40, 3'd2};
      8'h6b:        sn = {6'd40, SR2[1] ? 3'd4 : 3'd0};
      8'hbb:        sn = {6'd24, 3'd2};
      8'heb:        sn = {6'd20, 3'd4};
      8'h05, 8'h35: sn = {6'd8, 3'd1};
      default:      sn = {6'd63, 3'd0};
    endcase
  // Data leaves on falling edges and repeats until deselect.
  always @(negedge sclk)
    if (!cs_n && sn[2:0] != 3'd0 && rises >= sn[8:3])
    begin
      p = ((rises - sn[8:3]) * sn[2:0]) % 8;
      db = opc == 8'h05 ? {6'h00, write_enable_latch, 1'b0} : opc == 8'h35 ? SR2 : DBYTE;
      for (int n = 0; n < 4; n++)
        d_out[n] = n < sn[2:0] ? db[8 - sn[2:0] - p + n] : 1'b0;
      if (sn[2:0] == 3'd1)
        d_out[1] = db[7 - p];
      d_oe = sn[2:0] == 3'd1 ? 4'h2 : sn[2:0] == 3'd2 ? 4'h3 : 4'hf;
    end
endmodule

// >>> dv/sfh_ctrl_tb.sv
// Self-checking bench for the serial flash host controller.
module sfh_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;     // Bus clock.
  logic        presetn = 1'b0;  // Reset, active low.
  logic        psel = 1'b0;     // Bus select.
  logic        penable = 1'b0;  // Access phase.
  logic        pwrite = 1'b0;   // Direction.
  logic [11:0] paddr = 12'h000; // Address.
  logic [31:0] pwdata = 32'h0;  // Write data.
  logic [31:0] a;               // Flash address, random except 32'h12 for the 8'h48 read.
  wire  [31:0] prdata;
  wire         pready, pslverr, sclk, cs_n;
  wire  [3:0]  h_out, h_oe, d_out, d_oe, lanes;
  int          failures = 0, n_compared = 0, cyc = 0;
  logic [32:0] expq [$];        // Expected {error, data} of checked reads.
  logic [7:0]  ops [7] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h48};
  logic [31:0] fmts [7] = '{32'h1001, 32'h1041, 32'h10c1, 32'h1141, 32'h1086,
                            32'h1127, 32'h1041};
  always #25 pclk = ~pclk;
  // Released lanes are pulled up.
  assign lanes = (h_oe & h_out) | (~h_oe & d_oe & d_out) | ~(h_oe | d_oe);
  sfh_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_sclk(sclk), .flash_cs_n(cs_n), .flash_lane_out(h_out),
    .flash_lane_oe(h_oe), .flash_lane_in(lanes));
  sfh_flash_dev dev_u (.sclk(sclk), .cs_n(cs_n), .lanes(lanes), .d_out(d_out), .d_oe(d_oe));
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("failures=%0d compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One bus transfer; waits an edge after release so drives never collide.
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, ad, 32'h0);
  endtask
  // Runs one command, checks completion status, then clears the sticky flags.
  task automatic cmd(input logic [7:0] op, input logic [31:0] ad, input logic [31:0] fmt,
                     input logic [31:0] st);
    apb(1'b1, 12'h004, ad);
    apb(1'b1, 12'h008, fmt);
    apb(1'b1, 12'h000, {23'h0, 1'b1, op});
    repeat (fmt[13] ? 2 : 1)
    begin
      while (cs_n)
        @(posedge pclk);
      while (!cs_n)
        @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
    rd(12'h010, {1'b0, st});
    apb(1'b1, 12'h010, 32'h6);
  endtask
  // ==========================================================
  // Scoreboard: each completed checked read takes the oldest note.
  // ==========================================================
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && expq.size() > 0)
      chk({pslverr, prdata}, expq.pop_front());
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(84593));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 33'h005);
    rd(12'h008, 33'h0);
    rd(12'h010, 33'h0);
    apb(1'b1, 12'h020, 32'h0);
    rd(12'h020, 33'h1_0000_0000);
    cmd(8'h05, 32'h0, 32'h1000, 32'h2);
    rd(12'h00c, 33'h0);
    cmd(8'h06, 32'h0, 32'h0, 32'h2);
    cmd(8'h05, 32'h0, 32'h1000, 32'h2);
    rd(12'h00c, {1'b0, {4{8'h02}}});
    cmd(8'h05, 32'h0, 32'h7000, 32'h2);
    rd(12'h00c, {1'b0, {4{8'h02}}});
    cmd(8'h04, 32'h0, 32'h0, 32'h2);
    cmd(8'h35, 32'h0, 32'h1000, 32'h2);
    rd(12'h00c, {1'b0, {4{8'h62}}});
    cmd(8'h05, 32'h0, 32'h1000, 32'h2);
    rd(12'h00c, 33'h0);
    cmd(8'h77, 32'h5000_0000, 32'h7, 32'h2);
    foreach (ops[i])
    begin
      a = (ops[i] == 8'h48) ? 32'h12 : $urandom();
      cmd(ops[i], a, fmts[i], ops[i] == 8'h48 ? 32'h6 : 32'h2);
      rd(12'h00c, {1'b0, {4{8'h96}}});
    end
    stop_test();
  end
endmodule
